/* File: rtl/tmc_pkg.sv */
/*
 * Shared constants for the thermal monitor configuration bank: register
 * indices, field positions, reset values, pin roles and limit helpers.
 * Assumes a byte-wide register space where each register sits in one
 * 32-bit word at byte address four times its index.
 */
package tmc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices (byte address = index * 4)
   localparam logic [7:0] IDX_CFG     = 8'h7d;
   localparam logic [7:0] IDX_TEST1   = 8'h7e;
   localparam logic [7:0] IDX_TEST2   = 8'h7f;
   localparam logic [7:0] IDX_MAXSPD0 = 8'h38;
   localparam logic [7:0] IDX_LIMIT0  = 8'h6a;
   localparam logic [7:0] IDX_CTRL    = 8'h40;
   localparam logic [7:0] IDX_GPIO    = 8'h41;
   localparam logic [7:0] IDX_STATUS  = 8'h42;

   localparam int unsigned NUM_CH  = 3;
   localparam int unsigned ADR_LSB = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned CFG_PIN_LSB   = 0;
   localparam int unsigned CFG_THERMAL_LIMIT_PIN_DIS = 2;
   localparam int unsigned CFG_MAXSPD    = 3;
   localparam int unsigned CFG_BYP_LSB   = 4;
   localparam int unsigned CTRL_LOCK     = 0;
   localparam int unsigned CTRL_TWOS     = 1;
   localparam int unsigned GPIO_DIR      = 0;
   localparam int unsigned GPIO_OUT      = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic [7:0] TEST_RESET    = 8'h00;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] GPIO_RESET    = 8'h00;
   localparam logic [7:0] LIMIT_RESET   = 8'h00;
   localparam logic [7:0] MAXSPD_RESET  = 8'hff;
   localparam logic [7:0] FULL_SPEED    = 8'hff;
   localparam logic [7:0] LIMIT_OFF_OFS = 8'h00;   // -64 C in offset-64 coding
   localparam logic [7:0] LIMIT_OFF_TWO = 8'h80;   // -128 C in two's complement

   typedef enum logic [1:0] {
      PIN_TACH  = 2'b00,
      PIN_THERMAL_LIMIT_PIN = 2'b01,
      PIN_ALERT = 2'b10,
      PIN_GPIO  = 2'b11
   } tmc_pin_role_t;

   ////////////////////////////////////////////////////////////////////////////
   // Limit helpers
   function automatic logic limit_off(input logic [7:0] limit, input logic twos);
      limit_off = (limit == (twos ? LIMIT_OFF_TWO : LIMIT_OFF_OFS));
   endfunction : limit_off

   function automatic logic limit_hit(input logic [7:0] temp, input logic [7:0] limit,
                                      input logic twos);
      if (limit_off(limit, twos)) begin
         limit_hit = 1'b0;
      end else if (twos) begin
         limit_hit = $signed(temp) > $signed(limit);
      end else begin
         limit_hit = temp > limit;
      end
   endfunction : limit_hit

endpackage : tmc_pkg

/* File: rtl/tmc_reg_if.sv */
/*
 * Register access carrier between the bus slave and the register bank.
 * Assumes one clock; wr is a one-cycle strobe, rdata is combinational.
 */
interface tmc_reg_if;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport bus  (output wr, output idx, output wdata, input rdata);
   modport regs (input wr, input idx, input wdata, output rdata);
endinterface : tmc_reg_if

/* File: rtl/tmc_wb_slave.sv */
/*
 * Classic Wishbone slave front end for the configuration bank.
 * Assumes a single-cycle master that holds its request until ack.
 * Ack follows one cycle after the request is seen; writes land on the
 * edge where the master samples ack.
 */
module tmc_wb_slave (
   input  wire logic        ref_clk,   // System clock
   input  wire logic        resetn,    // Synchronous reset, active low
   input  wire logic        wb_cyc_i,  // Bus cycle
   input  wire logic        wb_stb_i,  // Strobe
   input  wire logic        wb_we_i,   // Write enable
   input  wire logic [9:0]  wb_adr_i,  // Byte address
   input  wire logic [3:0]  wb_sel_i,  // Byte lanes
   input  wire logic [31:0] wb_dat_i,  // Write data
   output logic      [31:0] wb_dat_o,  // Read data
   output logic             wb_ack_o,  // Acknowledge
   tmc_reg_if.bus           rf         // Register bank side
);

   logic aligned;
   logic req;

   assign aligned  = (wb_adr_i[tmc_pkg::ADR_LSB-1:0] == 2'h0);
   assign req      = wb_cyc_i & wb_stb_i;
   assign rf.idx   = wb_adr_i[9:tmc_pkg::ADR_LSB];
   assign rf.wdata = wb_dat_i[7:0];
   // Narrow registers live in lane 0; other lanes alone write nothing
   assign rf.wr    = req & wb_ack_o & wb_we_i & wb_sel_i[0] & aligned;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req & ~wb_ack_o) begin
         wb_dat_o <= aligned ? {24'h00_0000, rf.rdata} : 32'h0000_0000;
      end
   end

endmodule : tmc_wb_slave

/* File: rtl/tmc_config_bank.sv */
/*
 * Configuration bank of a thermal and voltage monitor: pin role routing,
 * overtemperature output, fan response and attenuator bypass, plus two
 * read-only factory test registers.
 * Assumes temperatures and fan duties come from logic on ref_clk, and that
 * the multi-function pin is resolved outside from output and enable.
 */
// The Wishbone register port is this design's own decision.
module tmc_config_bank (
   input  wire logic            ref_clk,          // System clock, 100 MHz
   input  wire logic            resetn,           // Synchronous reset, active low
   input  wire logic            wb_cyc_i,         // Wishbone cycle
   input  wire logic            wb_stb_i,         // Wishbone strobe
   input  wire logic            wb_we_i,          // Wishbone write enable
   input  wire logic [9:0]      wb_adr_i,         // Wishbone byte address
   input  wire logic [3:0]      wb_sel_i,         // Wishbone byte lanes
   input  wire logic [31:0]     wb_dat_i,         // Wishbone write data
   output logic      [31:0]     wb_dat_o,         // Wishbone read data
   output logic                 wb_ack_o,         // Wishbone acknowledge
   input  wire logic [2:0][7:0] temp_i,           // Measured temperatures
   input  wire logic [2:0][7:0] fan_duty_i,       // Duty from the fan loop
   input  wire logic            alert_req_i,      // Alert request from status logic
   input  wire logic            mf_pin_i,         // Multi-function pin level
   output logic                 mf_pin_o,         // Multi-function pin drive
   output logic                 mf_pin_oe_n,      // Pin enable, low drives
   output logic                 fan_tach_four_o,  // Tach four, synchronised
   output logic [2:0][7:0]      fan_duty_o,       // Duty to the fan drivers
   output logic                 overtemp_o,       // Overtemperature, active high
   output logic [3:0]           att_bypass_o      // Attenuator bypass per rail
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   tmc_reg_if rf ();

   logic [7:0]      cfg_r;
   logic [7:0]      test1_r;
   logic [7:0]      test2_r;
   logic [7:0]      ctrl_r;
   logic [7:0]      gpio_r;
   logic [2:0][7:0] limit_r;
   logic [2:0][7:0] maxspd_r;
   logic            pin_s1_r;
   logic            pin_s2_r;
   logic [2:0]      ch_hit;
   logic            ovt_nxt;
   logic            locked;
   logic            twos;
   logic            cfg_wr;

   tmc_pkg::tmc_pin_role_t role;

   tmc_wb_slave u_slave (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .rf       (rf.bus)
   );

   assign locked = ctrl_r[tmc_pkg::CTRL_LOCK];
   assign twos   = ctrl_r[tmc_pkg::CTRL_TWOS];
   assign role   = tmc_pkg::tmc_pin_role_t'(cfg_r[tmc_pkg::CFG_PIN_LSB +: 2]);
   assign cfg_wr = rf.wr && (rf.idx == tmc_pkg::IDX_CFG) && !locked;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_r <= tmc_pkg::CFG_RESET;
      end else if (cfg_wr) begin
         cfg_r <= rf.wdata;
      end
   end

   // Factory test registers hold their reset value; writes are dropped
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         test1_r <= tmc_pkg::TEST_RESET;
         test2_r <= tmc_pkg::TEST_RESET;
      end
   end

   // Lock is sticky until reset, so software cannot unlock itself
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl_r <= tmc_pkg::CTRL_RESET;
      end else if (rf.wr && (rf.idx == tmc_pkg::IDX_CTRL) && !locked) begin
         ctrl_r <= rf.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         gpio_r <= tmc_pkg::GPIO_RESET;
      end else if (rf.wr && (rf.idx == tmc_pkg::IDX_GPIO)) begin
         gpio_r <= rf.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            limit_r[i]  <= tmc_pkg::LIMIT_RESET;
            maxspd_r[i] <= tmc_pkg::MAXSPD_RESET;
         end
      end else if (rf.wr) begin
         for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            if (rf.idx == tmc_pkg::IDX_LIMIT0 + 8'(i)) begin
               limit_r[i] <= rf.wdata;
            end
            if (rf.idx == tmc_pkg::IDX_MAXSPD0 + 8'(i)) begin
               maxspd_r[i] <= rf.wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      rf.rdata = 8'h00;
      case (rf.idx)
         tmc_pkg::IDX_CFG:    rf.rdata = cfg_r;
         tmc_pkg::IDX_TEST1:  rf.rdata = test1_r;
         tmc_pkg::IDX_TEST2:  rf.rdata = test2_r;
         tmc_pkg::IDX_CTRL:   rf.rdata = ctrl_r;
         tmc_pkg::IDX_GPIO:   rf.rdata = {5'h00, pin_s2_r, gpio_r[1:0]};
         tmc_pkg::IDX_STATUS: rf.rdata = {3'h0, ch_hit, pin_s2_r, overtemp_o};
         default: begin
            for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
               if (rf.idx == tmc_pkg::IDX_LIMIT0 + 8'(i)) begin
                  rf.rdata = limit_r[i];
               end
               if (rf.idx == tmc_pkg::IDX_MAXSPD0 + 8'(i)) begin
                  rf.rdata = maxspd_r[i];
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
      end else begin
         pin_s1_r <= mf_pin_i;
         pin_s2_r <= pin_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overtemperature and fan response

   always_comb begin
      for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
         ch_hit[i] = tmc_pkg::limit_hit(temp_i[i], limit_r[i], twos);
      end
   end

   assign ovt_nxt = (|ch_hit) && !cfg_r[tmc_pkg::CFG_THERMAL_LIMIT_PIN_DIS];

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         overtemp_o <= 1'b0;
      end else begin
         overtemp_o <= ovt_nxt;
      end
   end

   // Decided from the same next value so fans and flag move together
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fan_duty_o <= '0;
      end else begin
         for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            if (!ovt_nxt) begin
               fan_duty_o[i] <= fan_duty_i[i];
            end else if (cfg_r[tmc_pkg::CFG_MAXSPD]) begin
               fan_duty_o[i] <= maxspd_r[i];
            end else begin
               fan_duty_o[i] <= tmc_pkg::FULL_SPEED;
            end
         end
      end
   end

   // Bypassed rails read 0x00..0xff over 0 to 2.25 V in the front end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         att_bypass_o <= 4'h0;
      end else begin
         att_bypass_o <= cfg_r[tmc_pkg::CFG_BYP_LSB +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multi-function pin routing

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fan_tach_four_o <= 1'b0;
      end else begin
         fan_tach_four_o <= (role == tmc_pkg::PIN_TACH) ? pin_s2_r : 1'b0;
      end
   end

   // Thermal and alert roles are open drain: only ever pull low
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mf_pin_o    <= 1'b0;
         mf_pin_oe_n <= 1'b1;
      end else begin
         unique case (role)
            tmc_pkg::PIN_TACH: begin
               mf_pin_o    <= 1'b0;
               mf_pin_oe_n <= 1'b1;
            end
            tmc_pkg::PIN_THERMAL_LIMIT_PIN: begin
               mf_pin_o    <= 1'b0;
               mf_pin_oe_n <= !ovt_nxt;
            end
            tmc_pkg::PIN_ALERT: begin
               mf_pin_o    <= 1'b0;
               mf_pin_oe_n <= !alert_req_i;
            end
            tmc_pkg::PIN_GPIO: begin
               mf_pin_o    <= gpio_r[tmc_pkg::GPIO_OUT];
               mf_pin_oe_n <= !gpio_r[tmc_pkg::GPIO_DIR];
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_cfg_write;
      cfg_wr;
   endsequence

   sequence s_gpio_sel;
      s_cfg_write and ((rf.wdata[1:0] == 2'b11) && gpio_r[tmc_pkg::GPIO_DIR]);
   endsequence

   sequence s_ovt;
      ovt_nxt;
   endsequence

   property p_reset_cfg;
      $rose(resetn) |-> (cfg_r == tmc_pkg::CFG_RESET) && !overtemp_o;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg)
      else $error("configuration not zero after reset");

   property p_lock_freeze;
      (locked && rf.wr && (rf.idx == tmc_pkg::IDX_CFG)) |=> $stable(cfg_r);
   endproperty
   a_lock_freeze: assert property (p_lock_freeze)
      else $error("locked configuration changed");

   property p_test_ro;
      (rf.wr && (rf.idx == tmc_pkg::IDX_TEST1 || rf.idx == tmc_pkg::IDX_TEST2))
         |=> (test1_r == tmc_pkg::TEST_RESET) && (test2_r == tmc_pkg::TEST_RESET);
   endproperty
   a_test_ro: assert property (p_test_ro)
      else $error("test register took a write");

   property p_gpio_follow;
      s_gpio_sel |-> ##2 (!mf_pin_oe_n && (mf_pin_o == gpio_r[tmc_pkg::GPIO_OUT]));
   endproperty
   a_gpio_follow: assert property (p_gpio_follow)
      else $error("pin role change not seen next cycle");

   property p_tach_role;
      (role == tmc_pkg::PIN_TACH) |=> mf_pin_oe_n && (fan_tach_four_o == $past(pin_s2_r));
   endproperty
   a_tach_role: assert property (p_tach_role)
      else $error("tach role drives pin or loses input");

   property p_alert_role;
      (role == tmc_pkg::PIN_ALERT) |=> (mf_pin_oe_n == !$past(alert_req_i)) && !mf_pin_o;
   endproperty
   a_alert_role: assert property (p_alert_role)
      else $error("alert role does not follow request");

   property p_thermal_limit_pin_dis;
      cfg_r[tmc_pkg::CFG_THERMAL_LIMIT_PIN_DIS] |=> !overtemp_o;
   endproperty
   a_thermal_limit_pin_dis: assert property (p_thermal_limit_pin_dis)
      else $error("overtemperature while disabled");

   property p_ofs_off;
      (!twos && (limit_r == {3{tmc_pkg::LIMIT_OFF_OFS}})) |=> !overtemp_o;
   endproperty
   a_ofs_off: assert property (p_ofs_off)
      else $error("offset mode limit -64 did not disable");

   property p_two_off;
      (twos && (limit_r == {3{tmc_pkg::LIMIT_OFF_TWO}})) |=> !overtemp_o;
   endproperty
   a_two_off: assert property (p_two_off)
      else $error("twos mode limit -128 did not disable");

   property p_fan_full;
      (s_ovt and (!cfg_r[tmc_pkg::CFG_MAXSPD])) |=> overtemp_o
         && (fan_duty_o == {3{tmc_pkg::FULL_SPEED}});
   endproperty
   a_fan_full: assert property (p_fan_full)
      else $error("fans not at full speed on overtemperature");

   property p_fan_max;
      (s_ovt and cfg_r[tmc_pkg::CFG_MAXSPD]) |=> (fan_duty_o == $past(maxspd_r));
   endproperty
   a_fan_max: assert property (p_fan_max)
      else $error("fans not at programmed maximum");

   property p_bypass;
      s_cfg_write ##1 1'b1 |=> (att_bypass_o == $past(rf.wdata[7:4], 2));
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("attenuator bypass does not follow configuration");

endmodule : tmc_config_bank

/* File: verification/tmc_tb.sv */
/*
 * Self-checking bench for the thermal monitor configuration bank.
 * Assumes the bank answers each classic Wishbone request with one ack
 * and that outputs follow a landed write by the next clock edge.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 ref_clk;
   logic                 resetn;
   logic                 wb_cyc_i;
   logic                 wb_stb_i;
   logic                 wb_we_i;
   logic [9:0]           wb_adr_i;
   logic [3:0]           wb_sel_i;
   logic [31:0]          wb_dat_i;
   logic [31:0]          wb_dat_o;
   logic                 wb_ack_o;
   logic [2:0][7:0]      temp_i;
   logic [2:0][7:0]      fan_duty_i;
   logic                 alert_req_i;
   logic                 mf_pin_i;
   logic                 mf_pin_o;
   logic                 mf_pin_oe_n;
   logic                 fan_tach_four_o;
   logic [2:0][7:0]      fan_duty_o;
   logic                 overtemp_o;
   logic [3:0]           att_bypass_o;
   int                   errors;
   int                   cmp_count;
   logic [31:0]          rd;

   tmc_config_bank dut (
      .ref_clk         (ref_clk),
      .resetn          (resetn),
      .wb_cyc_i        (wb_cyc_i),
      .wb_stb_i        (wb_stb_i),
      .wb_we_i         (wb_we_i),
      .wb_adr_i        (wb_adr_i),
      .wb_sel_i        (wb_sel_i),
      .wb_dat_i        (wb_dat_i),
      .wb_dat_o        (wb_dat_o),
      .wb_ack_o        (wb_ack_o),
      .temp_i          (temp_i),
      .fan_duty_i      (fan_duty_i),
      .alert_req_i     (alert_req_i),
      .mf_pin_i        (mf_pin_i),
      .mf_pin_o        (mf_pin_o),
      .mf_pin_oe_n     (mf_pin_oe_n),
      .fan_tach_four_o (fan_tach_four_o),
      .fan_duty_o      (fan_duty_o),
      .overtemp_o      (overtemp_o),
      .att_bypass_o    (att_bypass_o)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle; only the watchdog ends a wait for ack
   task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   function automatic logic [9:0] ba(input logic [7:0] idx);
      ba = {idx, 2'b00};
   endfunction : ba

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, ba(idx), {24'h0, d}, 4'h1);
   endtask : wr

   task automatic rdchk(input logic [9:0] adr, input logic [7:0] exp);
      wb(1'b0, adr, 32'h0, 4'hf);
      chk(rd, {24'h0, exp});
   endtask : rdchk

   // Lets a landed write reach the registered outputs
   task automatic settle;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      cmp_count = 0;
      resetn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 10'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      temp_i = {8'h20, 8'h20, 8'h20};
      fan_duty_i = {8'h33, 8'h22, 8'h11};
      alert_req_i = 1'b0;
      mf_pin_i = 1'b0;
      do_reset();
      rdchk(ba(tmc_pkg::IDX_CFG), 8'h00);
      rdchk(ba(tmc_pkg::IDX_TEST1), 8'h00);
      rdchk(ba(tmc_pkg::IDX_TEST2), 8'h00);
      settle();
      chk({28'h0, att_bypass_o}, 32'h0);
      chk({31'h0, mf_pin_oe_n}, 32'h1);
      chk({8'h0, fan_duty_o}, 32'h00332211);
      // Tach role passes the pin through its synchroniser
      @(posedge ref_clk);
      mf_pin_i <= 1'b1;
      settle();
      chk({31'h0, fan_tach_four_o}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(tmc_pkg::IDX_CFG, 8'h10 << i);
         settle();
         chk({28'h0, att_bypass_o}, 32'h1 << i);
      end
      wb(1'b1, ba(tmc_pkg::IDX_CFG), 32'h30, 4'h0);
      rdchk(ba(tmc_pkg::IDX_CFG), 8'h80);
      wr(tmc_pkg::IDX_TEST1, 8'ha5);
      wr(tmc_pkg::IDX_TEST2, 8'h5a);
      rdchk(ba(tmc_pkg::IDX_TEST1), 8'h00);
      rdchk(ba(tmc_pkg::IDX_TEST2), 8'h00);
      rdchk(10'h3fc, 8'h00);
      rdchk(ba(tmc_pkg::IDX_CFG) | 10'h1, 8'h00);
      // Alert role drives low only while requested
      wr(tmc_pkg::IDX_CFG, 8'h02);
      alert_req_i <= 1'b1;
      settle();
      chk({31'h0, mf_pin_oe_n}, 32'h0);
      chk({31'h0, fan_tach_four_o}, 32'h0);
      @(posedge ref_clk);
      alert_req_i <= 1'b0;
      settle();
      chk({31'h0, mf_pin_oe_n}, 32'h1);
      // Output direction set first so the role change drives at once
      wr(tmc_pkg::IDX_GPIO, 8'h03);
      wr(tmc_pkg::IDX_CFG, 8'h03);
      settle();
      chk({31'h0, mf_pin_oe_n}, 32'h0);
      chk({31'h0, mf_pin_o}, 32'h1);
      rdchk(ba(tmc_pkg::IDX_GPIO), 8'h07);
      wr(tmc_pkg::IDX_GPIO, 8'h00);
      settle();
      chk({31'h0, mf_pin_oe_n}, 32'h1);
      // Thermal role, channel 0 above its limit
      wr(tmc_pkg::IDX_CFG, 8'h01);
      wr(tmc_pkg::IDX_LIMIT0, 8'h40);
      temp_i <= {8'h20, 8'h20, 8'h50};
      settle();
      chk({31'h0, overtemp_o}, 32'h1);
      chk({31'h0, mf_pin_oe_n}, 32'h0);
      chk({8'h0, fan_duty_o}, 32'h00ffffff);
      rdchk(ba(tmc_pkg::IDX_STATUS), 8'h07);
      wr(tmc_pkg::IDX_LIMIT0, 8'h00);
      settle();
      chk({31'h0, overtemp_o}, 32'h0);
      chk({31'h0, mf_pin_oe_n}, 32'h1);
      wr(tmc_pkg::IDX_LIMIT0, 8'h40);
      wr(tmc_pkg::IDX_MAXSPD0, 8'h80);
      wr(tmc_pkg::IDX_MAXSPD0 + 8'h1, 8'h90);
      wr(tmc_pkg::IDX_CFG, 8'h09);
      settle();
      chk({8'h0, fan_duty_o}, 32'h00ff9080);
      wr(tmc_pkg::IDX_CFG, 8'h0d);
      settle();
      chk({31'h0, overtemp_o}, 32'h0);
      chk({31'h0, mf_pin_oe_n}, 32'h1);
      // Two's complement: 0x80 disables, 0xf0 is a negative limit
      // Other channels must read -128 too, or 0x00 means zero degrees
      wr(tmc_pkg::IDX_LIMIT0 + 8'h1, 8'h80);
      wr(tmc_pkg::IDX_LIMIT0 + 8'h2, 8'h80);
      wr(tmc_pkg::IDX_CTRL, 8'h02);
      wr(tmc_pkg::IDX_CFG, 8'h01);
      wr(tmc_pkg::IDX_LIMIT0, 8'h80);
      settle();
      chk({31'h0, overtemp_o}, 32'h0);
      wr(tmc_pkg::IDX_LIMIT0, 8'hf0);
      settle();
      chk({31'h0, overtemp_o}, 32'h1);
      wr(tmc_pkg::IDX_CTRL, 8'h03);
      wr(tmc_pkg::IDX_CFG, 8'h00);
      rdchk(ba(tmc_pkg::IDX_CFG), 8'h01);
      settle();
      chk({31'h0, overtemp_o}, 32'h1);
      // Second reset clears the sticky lock
      @(posedge ref_clk);
      do_reset();
      rdchk(ba(tmc_pkg::IDX_CFG), 8'h00);
      wr(tmc_pkg::IDX_CFG, 8'h20);
      rdchk(ba(tmc_pkg::IDX_CFG), 8'h20);
      test_done();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      test_done();
   end

endmodule : tb
